// [upirc_pkg.sv]
// Constants, register map and state type for the interrupt and reset controller
package upirc_pkg;

	// Register offsets (byte addresses on the 8-bit address bus)
	localparam logic [7:0] OFF_MODE     = 8'h0c;
	localparam logic [7:0] OFF_IRQ_CFG  = 8'h10;
	localparam logic [7:0] OFF_USB_EN   = 8'h14;
	localparam logic [7:0] OFF_USB_STAT = 8'h18;
	localparam logic [7:0] OFF_DMA_EN   = 8'h1c;
	localparam logic [7:0] OFF_DMA_STAT = 8'h20;
	localparam logic [7:0] OFF_PIN_STAT = 8'h24;

	// Mode register fields
	localparam int MODE_GLOBAL_EN_BIT = 3;
	localparam int MODE_CLK_AON_BIT   = 7;
	localparam logic [15:0] MODE_RST  = 16'h0000;

	// Interrupt configuration fields
	localparam int CFG_SIGNAL_MODE_BIT = 0;
	localparam int CFG_POLARITY_BIT    = 1;
	localparam int CFG_CTRL_PIPE_LSB   = 2;
	localparam int CFG_IN_PIPE_LSB     = 4;
	localparam int CFG_OUT_PIPE_LSB    = 6;
	localparam logic [7:0] CFG_RST     = 8'h00;

	// Pipe interrupt modes
	localparam logic [1:0] PIPE_ACK_ONLY = 2'h0;
	localparam logic [1:0] PIPE_ACK_NAK  = 2'h1;
	localparam logic [1:0] PIPE_NAK_ONLY = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int IRQ_PULSE_NS   = 60;
	localparam int IRQ_PULSE_CYC  = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_PULSE_NS   = 200;
	localparam int POR_PULSE_CYC  = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIP_FILTER_NS  = 11000;
	localparam int DIP_FILTER_CYC = DIP_FILTER_NS / CLK_PERIOD_NS;
	localparam int EXT_RST_US     = 500;
	localparam int EXT_RST_CYC    = EXT_RST_US * 1000 / CLK_PERIOD_NS;

	// Power-on reset sequencer
	typedef enum logic [1:0] {
		POR_IDLE  = 2'b00,
		POR_DIP   = 2'b01,
		POR_PULSE = 2'b10
	} upirc_por_e;

endpackage : upirc_pkg

// [upirc_core.sv]
// Interrupt pin, status/enable registers and power-on reset control
`timescale 1ns/1ps
module upirc_core #(
	parameter int USB_W        = 16,
	parameter int DMA_W        = 16,
	parameter int EXT_RST_MIN  = upirc_pkg::EXT_RST_CYC
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic [1:0]  regByteEn,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	output logic             regRdValid,
	// Event sources
	input  wire logic [USB_W-1:0] usbEvt,
	input  wire logic [DMA_W-1:0] dmaEvt,
	input  wire logic [2:0]  pipeAck,
	input  wire logic [2:0]  pipeNak,
	// Supply, reset and wake inputs
	input  wire logic        coreSupplyOk,
	input  wire logic        powerSharing,
	input  wire logic        supplyBelowTrip,
	input  wire logic        resetPinTied,
	input  wire logic        resetPinN,
	input  wire logic        suspended,
	input  wire logic        vbusDetect,
	// Pins and status outputs
	output logic             irqPin,
	output logic             suspendPin,
	output logic             ioOutEn,
	output logic             otgEnable,
	output logic             clkWakeReq,
	output logic             chipRst,
	output logic             extRstShort
);
	import upirc_pkg::*;

	localparam int DIPW = $clog2(DIP_FILTER_CYC + 2);
	localparam int PORW = $clog2(POR_PULSE_CYC + 1);
	localparam int EXTW = $clog2(EXT_RST_MIN + 1);
	localparam int PLSW = $clog2(IRQ_PULSE_CYC + 1);

	// Widths the register port cannot serve are refused
	if (USB_W < 4 || USB_W > 16 || DMA_W < 1 || DMA_W > 16 || EXT_RST_MIN < 1) begin : g_chk
		$error("upirc_core: unsupported parameter values");
	end

	// Pipe mode decode, shared by all three pipes
	function automatic logic pipeFires(input logic [1:0] mode, input logic ack,
		input logic nak);
		case (mode)
			PIPE_ACK_ONLY: pipeFires = ack;
			PIPE_ACK_NAK:  pipeFires = ack | nak;
			PIPE_NAK_ONLY: pipeFires = nak;
			default:       pipeFires = ack;
		endcase
	endfunction : pipeFires

	// Byte-lane mask of a write
	function automatic logic [15:0] laneMask(input logic [1:0] be);
		laneMask = {{8{be[1]}}, {8{be[0]}}};
	endfunction : laneMask

	// State
	logic [15:0]      modeReg;
	logic [7:0]       cfgReg;
	logic [USB_W-1:0] usbEn;
	logic [USB_W-1:0] usbStat;
	logic [DMA_W-1:0] dmaEn;
	logic [DMA_W-1:0] dmaStat;
	logic             irqArmed;
	logic             anyPrev;
	logic [PLSW-1:0]  pulseCnt;
	upirc_por_e       porState;
	logic [DIPW-1:0]  dipCnt;
	logic [PORW-1:0]  porCnt;
	logic [EXTW-1:0]  extCnt;
	logic             coreOkPrev;
	logic             vbusPrev;
	logic             intRst;

	logic [15:0]      next_modeReg;
	logic [7:0]       next_cfgReg;
	logic [USB_W-1:0] next_usbEn;
	logic [USB_W-1:0] next_usbStat;
	logic [DMA_W-1:0] next_dmaEn;
	logic [DMA_W-1:0] next_dmaStat;
	logic             next_irqArmed;
	logic             next_anyPrev;
	logic [PLSW-1:0]  next_pulseCnt;
	logic             next_irqPin;
	logic [15:0]      next_regRdData;
	logic             next_regRdValid;
	upirc_por_e       next_porState;
	logic [DIPW-1:0]  next_dipCnt;
	logic [PORW-1:0]  next_porCnt;
	logic [EXTW-1:0]  next_extCnt;
	logic             next_extRstShort;
	logic             next_chipRst;
	logic             next_clkWakeReq;

	logic [USB_W-1:0] usbSet;
	logic [2:0]       pipeHit;
	logic [15:0]      wMask;
	logic             anyEnabled;
	logic             globalEn;
	logic             pulseMode;
	logic             activeHigh;

	// Chip logic is held in reset by the bus reset or chipRst (reset pulse when the pin is tied, else the reset pin)
	assign intRst     = sys_rst | chipRst;
	assign globalEn   = modeReg[MODE_GLOBAL_EN_BIT];
	assign pulseMode  = cfgReg[CFG_SIGNAL_MODE_BIT];
	assign activeHigh = cfgReg[CFG_POLARITY_BIT];
	assign wMask      = laneMask(regByteEn);

	// Per-pipe interrupt shaping
	for (genvar p = 0; p < 3; p++) begin : g_pipe
		assign pipeHit[p] = pipeFires(cfgReg[CFG_CTRL_PIPE_LSB + 2*p +: 2],
			pipeAck[p], pipeNak[p]);
	end

	// Low three USB status bits belong to the control, IN and OUT pipes
	assign usbSet = usbEvt | {{(USB_W-3){1'b0}}, pipeHit};

	// Masked OR of everything pending
	assign anyEnabled = (|(usbStat & usbEn)) | (|(dmaStat & dmaEn));

	// Register file next values; events beat a clear in the same cycle
	always_comb begin
		next_modeReg = modeReg;
		next_cfgReg  = cfgReg;
		next_usbEn   = usbEn;
		next_dmaEn   = dmaEn;
		next_usbStat = usbStat | usbSet;
		next_dmaStat = dmaStat | dmaEvt;
		if (regWr) begin
			case (regAddr)
				OFF_MODE: begin
					next_modeReg = (modeReg & ~wMask) | (regWrData & wMask);
				end
				OFF_IRQ_CFG: begin
					if (regByteEn[0]) begin
						next_cfgReg = regWrData[7:0];
					end
				end
				OFF_USB_EN: begin
					next_usbEn = USB_W'((usbEn & ~wMask[USB_W-1:0]) |
						(regWrData[USB_W-1:0] & wMask[USB_W-1:0]));
				end
				OFF_DMA_EN: begin
					next_dmaEn = DMA_W'((dmaEn & ~wMask[DMA_W-1:0]) |
						(regWrData[DMA_W-1:0] & wMask[DMA_W-1:0]));
				end
				OFF_USB_STAT: begin
					// Only written lanes clear; a partial write leaves other bytes pending
					next_usbStat = (usbStat & ~(regWrData[USB_W-1:0] & wMask[USB_W-1:0]))
						| usbSet;
				end
				OFF_DMA_STAT: begin
					next_dmaStat = (dmaStat & ~(regWrData[DMA_W-1:0] & wMask[DMA_W-1:0]))
						| dmaEvt;
				end
				default: begin
				end
			endcase
		end
	end

	// Register read path, one cycle after the strobe; unmapped reads zero
	always_comb begin
		next_regRdValid = regRd;
		next_regRdData  = regRdData;
		if (regRd) begin
			case (regAddr)
				OFF_MODE:     next_regRdData = modeReg;
				OFF_IRQ_CFG:  next_regRdData = {8'h00, cfgReg};
				OFF_USB_EN:   next_regRdData = 16'(usbEn);
				OFF_USB_STAT: next_regRdData = 16'(usbStat);
				OFF_DMA_EN:   next_regRdData = 16'(dmaEn);
				OFF_DMA_STAT: next_regRdData = 16'(dmaStat);
				OFF_PIN_STAT: next_regRdData = {12'h000, extRstShort, irqArmed,
					anyEnabled, irqPin};
				default:      next_regRdData = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (intRst) begin
			modeReg <= MODE_RST;
			cfgReg  <= CFG_RST;
			usbEn   <= '0;
			usbStat <= '0;
			dmaEn   <= '0;
			dmaStat <= '0;
		end else begin
			modeReg <= next_modeReg;
			cfgReg  <= next_cfgReg;
			usbEn   <= next_usbEn;
			usbStat <= next_usbStat;
			dmaEn   <= next_dmaEn;
			dmaStat <= next_dmaStat;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			regRdData  <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			regRdData  <= next_regRdData;
			regRdValid <= next_regRdValid;
		end
	end

	// Pin driver. The arm latch is only dropped when no enabled status is pending, so
	// turning the global enable off leaves an asserted level-mode pin standing.
	always_comb begin
		next_irqArmed = irqArmed;
		next_pulseCnt = pulseCnt;
		next_anyPrev  = anyEnabled & globalEn;
		if (!anyEnabled) begin
			next_irqArmed = 1'b0;
		end else if (globalEn) begin
			next_irqArmed = 1'b1;
		end
		if (pulseCnt != '0) begin
			next_pulseCnt = PLSW'(pulseCnt - 1'b1);
		end
		if (anyEnabled && globalEn && !anyPrev) begin
			next_pulseCnt = PLSW'(IRQ_PULSE_CYC);
		end
		if (!coreSupplyOk) begin
			next_irqPin = 1'b0;
		end else if (pulseMode) begin
			next_irqPin = (next_pulseCnt != '0) ? activeHigh : ~activeHigh;
		end else begin
			next_irqPin = next_irqArmed ? activeHigh : ~activeHigh;
		end
	end

	always_ff @(posedge mclk) begin
		if (intRst) begin
			irqArmed <= 1'b0;
			anyPrev  <= 1'b0;
			pulseCnt <= '0;
			irqPin   <= 1'b1;
		end else begin
			irqArmed <= next_irqArmed;
			anyPrev  <= next_anyPrev;
			pulseCnt <= next_pulseCnt;
			irqPin   <= next_irqPin;
		end
	end

	// Supply-state pins and clock wake
	always_comb begin
		next_clkWakeReq = suspended && !modeReg[MODE_CLK_AON_BIT] &&
			vbusDetect && !vbusPrev;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			suspendPin <= 1'b0;
			ioOutEn    <= 1'b0;
			otgEnable  <= 1'b0;
			vbusPrev   <= 1'b0;
			clkWakeReq <= 1'b0;
		end else begin
			suspendPin <= !coreSupplyOk || suspended;
			ioOutEn    <= coreSupplyOk && !chipRst;
			otgEnable  <= !powerSharing && coreSupplyOk;
			vbusPrev   <= vbusDetect;
			clkWakeReq <= next_clkWakeReq;
		end
	end

	// Internal power-on reset: dips longer than the filter time retrigger
	// the pulse; a cable plug-in in sharing mode does the same.
	always_comb begin
		next_porState = porState;
		next_dipCnt   = dipCnt;
		next_porCnt   = porCnt;
		case (porState)
			POR_IDLE: begin
				next_dipCnt = '0;
				if (powerSharing && coreSupplyOk && !coreOkPrev) begin
					next_porState = POR_PULSE;
					next_porCnt   = PORW'(POR_PULSE_CYC);
				end else if (supplyBelowTrip) begin
					next_porState = POR_DIP;
				end
			end
			POR_DIP: begin
				if (!supplyBelowTrip) begin
					// Supply back: only a long enough dip fires the pulse
					if (dipCnt > DIPW'(DIP_FILTER_CYC)) begin
						next_porState = POR_PULSE;
						next_porCnt   = PORW'(POR_PULSE_CYC);
					end else begin
						next_porState = POR_IDLE;
					end
				end else if (dipCnt <= DIPW'(DIP_FILTER_CYC)) begin
					next_dipCnt = DIPW'(dipCnt + 1'b1);
				end
			end
			POR_PULSE: begin
				if (porCnt > PORW'(1)) begin
					next_porCnt = PORW'(porCnt - 1'b1);
				end else begin
					next_porCnt   = '0;
					next_porState = POR_IDLE;
				end
			end
			default: begin
				next_porState = POR_IDLE;
			end
		endcase
	end

	// External reset length check and chip reset source select
	always_comb begin
		next_extCnt      = extCnt;
		next_extRstShort = extRstShort;
		if (!resetPinN) begin
			if (extCnt < EXTW'(EXT_RST_MIN)) begin
				next_extCnt = EXTW'(extCnt + 1'b1);
			end
		end else begin
			next_extCnt = '0;
			if (extCnt != '0) begin
				next_extRstShort = extCnt < EXTW'(EXT_RST_MIN);
			end
		end
		if (resetPinTied) begin
			next_chipRst = (next_porState == POR_PULSE);
		end else begin
			next_chipRst = !resetPinN;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			porState    <= POR_PULSE;
			dipCnt      <= '0;
			porCnt      <= PORW'(POR_PULSE_CYC);
			extCnt      <= '0;
			extRstShort <= 1'b0;
			chipRst     <= 1'b1;
			coreOkPrev  <= 1'b0;
		end else begin
			porState    <= next_porState;
			dipCnt      <= next_dipCnt;
			porCnt      <= next_porCnt;
			extCnt      <= next_extCnt;
			extRstShort <= next_extRstShort;
			chipRst     <= next_chipRst;
			coreOkPrev  <= coreSupplyOk;
		end
	end

endmodule : upirc_core

// [upirc_core_props.sv]
// Pin-level checks of the interrupt and reset controller
`timescale 1ns/1ps
module upirc_core_props (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [7:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic [1:0]  regByteEn,
	input wire logic        regWr,
	// Supply and wake
	input wire logic        coreSupplyOk,
	input wire logic        powerSharing,
	input wire logic        supplyBelowTrip,
	input wire logic        suspended,
	input wire logic        vbusDetect,
	// Outputs
	input wire logic        irqPin,
	input wire logic        suspendPin,
	input wire logic        ioOutEn,
	input wire logic        clkWakeReq,
	input wire logic        chipRst
);
	import upirc_pkg::*;
	logic [7:0] cfg, next_cfg;
	logic [8:0] dip, next_dip;
	logic       glob, next_glob, aon, next_aon, act, wrMode;
	// Shadow of config and mode bits; writes in chip reset are lost
	always_comb begin
		wrMode = regWr && !chipRst && regByteEn[0] && regAddr == OFF_MODE;
		next_cfg = (regWr && !chipRst && regByteEn[0] && regAddr == OFF_IRQ_CFG)
			? regWrData[7:0] : cfg;
		next_glob = wrMode ? regWrData[MODE_GLOBAL_EN_BIT] : glob;
		next_aon = wrMode ? regWrData[MODE_CLK_AON_BIT] : aon;
		next_dip = supplyBelowTrip ? dip + 9'h001 : 9'h000;
		act = (irqPin == cfg[CFG_POLARITY_BIT]);
	end
	always_ff @(posedge mclk) begin
		cfg <= (sys_rst || chipRst) ? CFG_RST : next_cfg;
		glob <= !(sys_rst || chipRst) && next_glob;
		aon <= !(sys_rst || chipRst) && next_aon;
		dip <= next_dip;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Pulse occupies exactly two cycles
	sequence s_pulse;
		act ##1 !act;
	endsequence
	a_sharing_pins: assert property (!coreSupplyOk [*2] |-> !irqPin && suspendPin && !ioOutEn)
		else $error("pins wrong without core supply");
	a_reset_idle: assert property ($fell(chipRst) && coreSupplyOk |-> irqPin)
		else $error("pin not idle high after reset");
	a_pulse_width: assert property ($changed(irqPin) && act && cfg[0] |=> s_pulse)
		else $error("pulse width wrong");
	a_level_hold: assert property ((act && !regWr && coreSupplyOk && !chipRst && !cfg[0]) [*2] |=> act)
		else $error("level pin dropped without a clear");
	a_off_holds: assert property ($fell(glob) && act && !cfg[0] |=> act [*2])
		else $error("pin released by global disable");
	a_off_idle: assert property ((!glob && !act && !regWr && coreSupplyOk) [*3] |=> !act)
		else $error("pin asserted while globally disabled");
	a_short_dip: assert property (supplyBelowTrip && dip < 9'h0c8 && !chipRst |=> !chipRst)
		else $error("reset pulse on a short dip");
	a_vbus_wake: assert property ($rose(vbusDetect) && suspended && !aon |=> clkWakeReq ##1 !clkWakeReq)
		else $error("no clock wake on vbus");
	a_plug_por: assert property ($rose(coreSupplyOk) && powerSharing |-> ##[1:3] chipRst)
		else $error("no reset on plug-in");
endmodule : upirc_core_props

// [upirc_host.sv]
// Firmware side of the register port
`timescale 1ns/1ps
module upirc_host (
	// Clock
	input wire logic         mclk,
	// Register port
	output logic [7:0]       regAddr,
	output logic [15:0]      regWrData,
	output logic [1:0]       regByteEn,
	output logic             regWr,
	output logic             regRd,
	input wire logic [15:0]  regRdData,
	input wire logic         regRdValid
);
	// Idle address and write-data lines show the inverse of the last value
	initial begin
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regByteEn = 2'h0;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] be);
		@(posedge mclk);
		#1;
		regAddr = a;
		regWrData = v;
		regByteEn = be;
		regWr = 1'b1;
		@(posedge mclk);
		#1;
		regWr = 1'b0;
		regAddr = ~a;
		regWrData = ~v;
	endtask : wr
	// Events are cleared with both byte lanes written
	task automatic clr(input logic [7:0] a, input logic [15:0] v);
		wr(a, v, 2'h3);
	endtask : clr
	// Answer lands one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] v, output logic ok);
		@(posedge mclk);
		#1;
		regAddr = a;
		regRd = 1'b1;
		@(posedge mclk);
		#1;
		regRd = 1'b0;
		regAddr = ~a;
		ok = regRdValid;
		v = regRdData;
	endtask : rd
endmodule : upirc_host

// [usb_periph_irq_reset_ctrl_tb.sv]
// Self-checking bench for the interrupt and reset controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin fails++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module usb_periph_irq_reset_ctrl_tb;
	import upirc_pkg::*;
	typedef struct {logic [7:0] cfg; logic [15:0] usb, dma, usbEn, dmaEn; logic hit;} upirc_row_s;
	logic        mclk = 1'b0, sys_rst = 1'b1, regWr, regRd, regRdValid, wv;
	logic [7:0]  regAddr;
	logic [15:0] regWrData, regRdData, d, usbEvt = 16'h0000, dmaEvt = 16'h0000;
	logic [1:0]  regByteEn;
	logic [2:0]  pipeAck = 3'h0, pipeNak = 3'h0;
	logic        coreSupplyOk = 1'b1, powerSharing = 1'b0, supplyBelowTrip = 1'b0;
	logic        resetPinTied = 1'b1, resetPinN = 1'b1, suspended = 1'b0, vbusDetect = 1'b0;
	logic        irqPin, suspendPin, ioOutEn, otgEnable, clkWakeReq, chipRst, extRstShort;
	int          fails = 0, totalChecks = 0, cycles = 0, n;
	// Ordinary cases: config, events, enables, whether the pin fires
	upirc_row_s  rows[5] = '{
		'{8'h00, 16'h0020, 16'h0000, 16'h0020, 16'h0000, 1'b1},
		'{8'h02, 16'h0000, 16'h0002, 16'h0000, 16'h0002, 1'b1},
		'{8'h01, 16'h0200, 16'h0000, 16'h0200, 16'h0000, 1'b1},
		'{8'h03, 16'h0000, 16'h0010, 16'h0000, 16'h0010, 1'b1},
		'{8'h00, 16'h0080, 16'h0000, 16'h0040, 16'h0000, 1'b0}};
	always #25 mclk = ~mclk;
	// Short external reset limit keeps the run brief
	upirc_core #(.EXT_RST_MIN(20)) dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regByteEn(regByteEn), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .regRdValid(regRdValid), .usbEvt(usbEvt), .dmaEvt(dmaEvt),
		.pipeAck(pipeAck), .pipeNak(pipeNak), .coreSupplyOk(coreSupplyOk),
		.powerSharing(powerSharing), .supplyBelowTrip(supplyBelowTrip),
		.resetPinTied(resetPinTied), .resetPinN(resetPinN), .suspended(suspended),
		.vbusDetect(vbusDetect), .irqPin(irqPin), .suspendPin(suspendPin), .ioOutEn(ioOutEn),
		.otgEnable(otgEnable), .clkWakeReq(clkWakeReq), .chipRst(chipRst),
		.extRstShort(extRstShort));
	upirc_host host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
		.regByteEn(regByteEn), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.regRdValid(regRdValid));
	task automatic completeRun();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : completeRun
	// Hang guard well above the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			completeRun();
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick
	task automatic waitChip(input logic v);
		n = 0;
		while (chipRst !== v && n < 400) begin
			tick(1);
			n++;
		end
	endtask : waitChip
	task automatic doReset();
		sys_rst = 1'b1;
		tick(6);
		sys_rst = 1'b0;
		waitChip(1'b0);
	endtask : doReset
	task automatic fire(input logic [15:0] u, input logic [15:0] m);
		usbEvt = u;
		dmaEvt = m;
		tick(1);
		usbEvt = 16'h0000;
		dmaEvt = 16'h0000;
	endtask : fire
	task automatic pipeTry(input int p, input logic nak, input logic hit);
		pipeNak[p] = nak;
		pipeAck[p] = !nak;
		tick(1);
		pipeAck = 3'h0;
		pipeNak = 3'h0;
		host.rd(OFF_USB_STAT, d, wv);
		`CHK("pipe status", hit, d[p])
		host.clr(OFF_USB_STAT, 16'hffff);
	endtask : pipeTry
	initial begin
		doReset();
		host.rd(OFF_MODE, d, wv);
		`CHK("mode after reset", MODE_RST, d)
		`CHK("read answered", 1'b1, wv)
		foreach (rows[i]) begin
			host.wr(OFF_IRQ_CFG, {8'h00, rows[i].cfg}, 2'h1);
			host.wr(OFF_USB_EN, rows[i].usbEn, 2'h3);
			host.wr(OFF_DMA_EN, rows[i].dmaEn, 2'h3);
			host.wr(OFF_MODE, 16'h0008, 2'h3);
			fire(rows[i].usb, rows[i].dma);
			tick(2);
			`CHK("pin raised", rows[i].hit ? rows[i].cfg[1] : ~rows[i].cfg[1], irqPin)
			tick(2);
			`CHK("pin later", rows[i].hit && !rows[i].cfg[0] ? rows[i].cfg[1] : ~rows[i].cfg[1], irqPin)
			host.rd(OFF_USB_STAT, d, wv);
			`CHK("usb status", rows[i].usb, d)
			host.rd(OFF_DMA_STAT, d, wv);
			`CHK("dma status", rows[i].dma, d)
			host.clr(OFF_USB_STAT, 16'hffff);
			host.clr(OFF_DMA_STAT, 16'hffff);
			tick(2);
			`CHK("pin cleared", ~rows[i].cfg[1], irqPin)
		end
		// Every pipe under every mode, ack then nak
		for (int p = 0; p < 3; p++) begin
			for (int m = 0; m < 4; m++) begin
				host.wr(OFF_IRQ_CFG, 16'(m << (CFG_CTRL_PIPE_LSB + 2 * p)), 2'h1);
				pipeTry(p, 1'b0, m != 2);
				pipeTry(p, 1'b1, m == 1 || m == 2);
			end
		end
		// Global enable: held off, then on, then off again
		host.wr(OFF_IRQ_CFG, 16'h0000, 2'h1);
		host.wr(OFF_USB_EN, 16'h0008, 2'h3);
		host.wr(OFF_MODE, 16'h0000, 2'h3);
		fire(16'h0008, 16'h0000);
		tick(3);
		`CHK("pin held off", 1'b1, irqPin)
		host.rd(OFF_USB_STAT, d, wv);
		`CHK("event recorded", 16'h0008, d)
		host.wr(OFF_MODE, 16'h0008, 2'h3);
		tick(2);
		`CHK("pin on enable", 1'b0, irqPin)
		host.wr(OFF_MODE, 16'h0000, 2'h3);
		tick(3);
		`CHK("pin after disable", 1'b0, irqPin)
		host.clr(OFF_USB_STAT, 16'h0008);
		tick(2);
		`CHK("pin after clear", 1'b1, irqPin)
		// Second reset in mid-run restores the config
		host.wr(OFF_IRQ_CFG, 16'h0003, 2'h1);
		doReset();
		host.rd(OFF_IRQ_CFG, d, wv);
		`CHK("config after reset", {8'h00, CFG_RST}, d)
		`CHK("pin after reset", 1'b1, irqPin)
		// Core supply lost, then cable plugged in while sharing
		coreSupplyOk = 1'b0;
		tick(3);
		`CHK("sharing irq", 1'b0, irqPin)
		`CHK("sharing suspend", 1'b1, suspendPin)
		`CHK("sharing drive", 1'b0, ioOutEn)
		// Host view: a low pin without VBUS must not count as a request
		`CHK("vbus qualified irq", 1'b0, !irqPin && vbusDetect)
		powerSharing = 1'b1;
		coreSupplyOk = 1'b1;
		waitChip(1'b1);
		`CHK("plug-in reset", 1'b1, chipRst)
		`CHK("otg off", 1'b0, otgEnable)
		waitChip(1'b0);
		powerSharing = 1'b0;
		// Short dip ignored, long dip gives one reset pulse
		supplyBelowTrip = 1'b1;
		tick(50);
		supplyBelowTrip = 1'b0;
		// A pulse would start one cycle after the supply returns
		tick(2);
		`CHK("short dip", 1'b0, chipRst)
		supplyBelowTrip = 1'b1;
		tick(DIP_FILTER_CYC + 4);
		`CHK("no reset during dip", 1'b0, chipRst)
		supplyBelowTrip = 1'b0;
		waitChip(1'b1);
		`CHK("long dip", 1'b1, chipRst)
		waitChip(1'b0);
		`CHK("reset width", POR_PULSE_CYC, n)
		// VBUS wakes the clock only with the clock-on bit clear
		suspended = 1'b1;
		vbusDetect = 1'b1;
		tick(1);
		`CHK("vbus wake", 1'b1, clkWakeReq)
		vbusDetect = 1'b0;
		host.wr(OFF_MODE, 16'h0080, 2'h3);
		vbusDetect = 1'b1;
		tick(1);
		`CHK("clock kept on", 1'b0, clkWakeReq)
		// External reset: a short hold is flagged, a full hold is not
		resetPinTied = 1'b0;
		resetPinN = 1'b0;
		tick(5);
		`CHK("ext reset follows pin", 1'b1, chipRst)
		resetPinN = 1'b1;
		waitChip(1'b0);
		tick(1);
		host.rd(OFF_PIN_STAT, d, wv);
		`CHK("short reset flagged", 16'h0009, d)
		// Host keeps the pin low past the minimum hold
		resetPinN = 1'b0;
		tick(25);
		resetPinN = 1'b1;
		tick(2);
		`CHK("full reset accepted", 1'b0, extRstShort)
		resetPinTied = 1'b1;
		completeRun();
	end
endmodule : usb_periph_irq_reset_ctrl_tb
bind upirc_core upirc_core_props u_props (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
	.regWrData(regWrData), .regByteEn(regByteEn), .regWr(regWr), .coreSupplyOk(coreSupplyOk),
	.powerSharing(powerSharing), .supplyBelowTrip(supplyBelowTrip), .suspended(suspended),
	.vbusDetect(vbusDetect), .irqPin(irqPin), .suspendPin(suspendPin), .ioOutEn(ioOutEn),
	.clkWakeReq(clkWakeReq), .chipRst(chipRst));
